// ==== rtl/current_sense_defines.svh ====
// Constants for the current sense reset steering block
`ifndef CURRENT_SENSE_DEFINES_SVH
`define CURRENT_SENSE_DEFINES_SVH
// Watchdog limit in microseconds and the clock period in picoseconds
`define WATCHDOG_LIMIT_US 30
`define CLK_PERIOD_PS 20000
// Longest time rounds down to whole cycles
`define WATCHDOG_CYCLES ((`WATCHDOG_LIMIT_US * 1000000) / `CLK_PERIOD_PS)
`define WD_COUNT_W 16
`define SEL_LINE_A 1'b0
`define SEL_LINE_B 1'b1
`endif

// ==== rtl/current_sense_pkg.sv ====
// Types shared by the current sense reset steering block
package current_sense_pkg;
   // Output modes, decoded from the mode-select and input four levels
   typedef enum logic [1:0] {
      MODE_SINGLE = 2'b00,
      MODE_PP_TWO = 2'b01,
      MODE_PP_FOUR = 2'b10
   } out_mode_t;
   // Measurement phase
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_RESET = 2'b01,
      PH_MEASURE = 2'b10,
      PH_FAULT = 2'b11
   } phase_t;
endpackage

// ==== rtl/reset_decode_if.sv ====
// Decoded reset request and steering between decoder and top
`timescale 1ns/1ps
interface reset_decode_if;
   import current_sense_pkg::*;
   logic reset_req; // Integrator reset active
   logic steer_valid; // Steering hint present this cycle
   logic steer_sel; // Line chosen by the hint
   out_mode_t mode; // Decoded output mode
   modport decoder (output reset_req, output steer_valid, output steer_sel, output mode);
   modport user (input reset_req, input steer_valid, input steer_sel, input mode);
endinterface

// ==== rtl/reset_decoder.sv ====
// Combinational reset logic and steering decode
`timescale 1ns/1ps
`include "current_sense_defines.svh"
module reset_decoder
   import current_sense_pkg::*;
#(
   parameter bit DUAL = 1'b1
) (
   // Inputs from the controller
   input wire logic in_one,
   input wire logic in_two,
   input wire logic in_three,
   input wire logic in_four,
   input wire logic mode_sel,
   // Decoded result
   reset_decode_if.decoder dec
);
   import current_sense_pkg::*;
   // three functions, mode picks one
   // Pick by variant and mode first, then decode only that function
   always_comb begin
      dec.steer_valid = 1'b0;
      dec.steer_sel = `SEL_LINE_A;
      if (!DUAL) begin
         dec.mode = MODE_SINGLE;
         dec.reset_req = in_one ^ in_two;
      end else if (mode_sel) begin
         if (!in_four) begin
            dec.mode = MODE_SINGLE;
            dec.reset_req = in_one ^ (in_two | in_three);
         end else begin
            dec.mode = MODE_PP_TWO;
            dec.reset_req = ~(in_one ^ (in_two | in_three));
            // input one picks A, two picks B
            dec.steer_valid = in_one ^ in_two;
            dec.steer_sel = in_two ? `SEL_LINE_B : `SEL_LINE_A;
         end
      end else begin
         dec.mode = MODE_PP_FOUR;
         dec.reset_req = (in_one & in_two) | (in_three & in_four);
         // one-not-two picks B, three-not-four picks A
         dec.steer_valid = (in_one & ~in_two) | (in_three & ~in_four);
         dec.steer_sel = (in_one & ~in_two) ? `SEL_LINE_B : `SEL_LINE_A;
      end
   end
endmodule

// ==== rtl/current_sense_ctrl.sv ====
// Reset steering and watchdog control of the current sensor
`timescale 1ns/1ps
`include "current_sense_defines.svh"
module current_sense_ctrl
   import current_sense_pkg::*;
#(
   parameter bit DUAL = 1'b1,
   parameter int unsigned WD_CYCLES = `WATCHDOG_CYCLES
) (
   // Clock, reset and enable
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic CLK_EN,
   // Gate timing inputs
   input wire logic RESET_IN_ONE,
   input wire logic RESET_IN_TWO,
   input wire logic RESET_IN_THREE,
   input wire logic RESET_IN_FOUR,
   input wire logic MODE_SEL,
   // Measurement steering and status
   output logic INTEG_RESET,
   output logic SENSE_LINE_A,
   output logic SENSE_LINE_B,
   output logic FAULT_N,
   output current_sense_pkg::out_mode_t MODE
);
   import current_sense_pkg::*;

   // ****************************************
   // Decoder
   // ****************************************
   reset_decode_if dec ();
   // variant picks how many functions exist
   reset_decoder #(.DUAL(DUAL)) u_dec (
      .in_one(RESET_IN_ONE),
      .in_two(RESET_IN_TWO),
      .in_three(RESET_IN_THREE),
      .in_four(RESET_IN_FOUR),
      .mode_sel(MODE_SEL),
      .dec(dec.decoder)
   );

   // ****************************************
   // State
   // ****************************************
   localparam logic [`WD_COUNT_W-1:0] WD_LIMIT = WD_CYCLES[`WD_COUNT_W-1:0];
   phase_t phase_r, phase_nxt; // Measurement phase
   logic [`WD_COUNT_W-1:0] wd_cnt_r, wd_cnt_nxt; // Time since last reset
   logic sel_r, sel_nxt; // Line of the coming measurement
   logic integ_r, integ_nxt; // Registered reset request
   logic line_a_r, line_a_nxt; // Line A measuring
   logic line_b_r, line_b_nxt; // Line B measuring
   logic fault_n_r, fault_n_nxt; // Active-low fault
   out_mode_t mode_r, mode_nxt; // Registered mode
   logic req_d_r; // Request one cycle ago, for edge detect
   logic reset_rise; // Reset begins this cycle

   assign reset_rise = dec.reset_req & ~req_d_r;

   // Next-state logic for phase, watchdog and steering
   always_comb begin
      phase_nxt = phase_r;
      wd_cnt_nxt = wd_cnt_r;
      sel_nxt = sel_r;
      fault_n_nxt = fault_n_r;
      integ_nxt = dec.reset_req;
      mode_nxt = dec.mode;
      line_a_nxt = 1'b0;
      line_b_nxt = 1'b0;
      // a live hint fixes the line, in or out of reset
      if (dec.steer_valid) begin
         sel_nxt = dec.steer_sel;
      end
      if (dec.reset_req) begin
         // In reset: watchdog restarts, no line measures
         phase_nxt = PH_RESET;
         wd_cnt_nxt = '0;
         if (reset_rise) begin
            fault_n_nxt = 1'b1;
         end
         // No hint: alternate on each new reset in a ping-pong mode, not the first after idle
         if (!dec.steer_valid && reset_rise && dec.mode != MODE_SINGLE
            && phase_r != PH_IDLE) begin
            sel_nxt = ~sel_r;
         end
      end else if (phase_r != PH_IDLE && phase_r != PH_FAULT) begin
         phase_nxt = PH_MEASURE;
         if (wd_cnt_r >= WD_LIMIT) begin
            phase_nxt = PH_FAULT;
            fault_n_nxt = 1'b0;
         end else begin
            wd_cnt_nxt = wd_cnt_r + `WD_COUNT_W'(1);
            if (dec.mode == MODE_SINGLE) begin
               line_a_nxt = 1'b1;
            end else if (dec.steer_valid) begin
               // lines follow the live levels; a two-wire hint
               // only exists outside reset while input three is low, so it cannot be latched earlier
               line_a_nxt = (dec.steer_sel == `SEL_LINE_A);
               line_b_nxt = (dec.steer_sel == `SEL_LINE_B);
            end else begin
               line_a_nxt = (sel_r == `SEL_LINE_A);
               line_b_nxt = (sel_r == `SEL_LINE_B);
            end
         end
      end
   end

   // Register stage, frozen while the enable is low
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         phase_r <= PH_IDLE;
         wd_cnt_r <= '0;
         sel_r <= `SEL_LINE_A;
         integ_r <= 1'b0;
         line_a_r <= 1'b0;
         line_b_r <= 1'b0;
         fault_n_r <= 1'b1;
         mode_r <= MODE_SINGLE;
         req_d_r <= 1'b0;
      end else if (CLK_EN) begin
         phase_r <= phase_nxt;
         wd_cnt_r <= wd_cnt_nxt;
         sel_r <= sel_nxt;
         integ_r <= integ_nxt;
         line_a_r <= line_a_nxt;
         line_b_r <= line_b_nxt;
         fault_n_r <= fault_n_nxt;
         mode_r <= mode_nxt;
         req_d_r <= dec.reset_req;
      end
   end

   assign INTEG_RESET = integ_r;
   assign SENSE_LINE_A = line_a_r;
   assign SENSE_LINE_B = line_b_r;
   assign FAULT_N = fault_n_r;
   assign MODE = mode_r;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);

   sequence s_measure_long;
      CLK_EN && !dec.reset_req && phase_r == PH_MEASURE && wd_cnt_r >= WD_LIMIT;
   endsequence
   sequence s_new_reset;
      CLK_EN && reset_rise;
   endsequence
   // Two-wire measurement with input one high, watchdog still running
   sequence s_two_wire_one;
      CLK_EN && dec.mode == MODE_PP_TWO && !dec.reset_req && RESET_IN_ONE && !RESET_IN_TWO
         && (phase_r == PH_RESET || phase_r == PH_MEASURE) && wd_cnt_r < WD_LIMIT;
   endsequence
   // New reset in a ping-pong mode with no steering hint present
   sequence s_bare_reset;
      CLK_EN && reset_rise && !dec.steer_valid && dec.mode != MODE_SINGLE && phase_r != PH_IDLE;
   endsequence

   chk_fault_on_expiry: assert property (s_measure_long |=> !FAULT_N)
      else $error("fault not raised after watchdog expiry");
   chk_fault_release: assert property (s_new_reset |=> FAULT_N)
      else $error("fault not released at new reset");
   chk_single_no_b: assert property (MODE == MODE_SINGLE |-> !SENSE_LINE_B)
      else $error("line B active in single mode");
   chk_lines_exclusive: assert property (!(SENSE_LINE_A && SENSE_LINE_B))
      else $error("both lines active");
   chk_reset_blocks: assert property (INTEG_RESET |-> !SENSE_LINE_A && !SENSE_LINE_B)
      else $error("line active during reset");
   chk_xor_decode: assert property (CLK_EN && DUAL && MODE_SEL && !RESET_IN_FOUR
      |=> INTEG_RESET == ($past(RESET_IN_ONE) ^ ($past(RESET_IN_TWO) | $past(RESET_IN_THREE))))
      else $error("single-ended reset decode wrong");
   chk_xnor_decode: assert property (CLK_EN && DUAL && MODE_SEL && RESET_IN_FOUR
      |=> INTEG_RESET == ~($past(RESET_IN_ONE) ^ ($past(RESET_IN_TWO) | $past(RESET_IN_THREE))))
      else $error("two-wire reset decode wrong");
   chk_andor_decode: assert property (CLK_EN && DUAL && !MODE_SEL
      |=> INTEG_RESET == (($past(RESET_IN_ONE) & $past(RESET_IN_TWO))
         | ($past(RESET_IN_THREE) & $past(RESET_IN_FOUR))))
      else $error("four-wire reset decode wrong");
   chk_unequal_reset: assert property (CLK_EN && !DUAL
      |=> INTEG_RESET == ($past(RESET_IN_ONE) ^ $past(RESET_IN_TWO)))
      else $error("single variant reset decode wrong");
   chk_two_wire_a: assert property (s_two_wire_one |=> SENSE_LINE_A && !SENSE_LINE_B)
      else $error("two-wire steering not to A while input one set");
   chk_four_wire_b: assert property (CLK_EN && dec.mode == MODE_PP_FOUR && dec.steer_valid
      && RESET_IN_ONE && !RESET_IN_TWO |=> sel_r == `SEL_LINE_B)
      else $error("four-wire steering not to B");
   chk_mode_decode: assert property (CLK_EN && DUAL && !MODE_SEL
      |=> MODE == MODE_PP_FOUR)
      else $error("mode not decoded from select");
   // Without a hint the coming measurement takes the other line
   chk_bare_alternate: assert property (s_bare_reset |=> sel_r != $past(sel_r))
      else $error("line not alternated at new reset");
   // A flagged fault keeps both lines quiet until the next reset
   chk_fault_silences: assert property (!FAULT_N |-> !SENSE_LINE_A && !SENSE_LINE_B)
      else $error("line active while fault flagged");
   // The single variant never leaves single output mode
   chk_single_variant: assert property (!DUAL |-> MODE == MODE_SINGLE)
      else $error("single variant left single mode");
endmodule

// ==== test/gate_timing_model.sv ====
// Controller model that drives the gate timing levels of the sensor
`timescale 1ns/1ps
module gate_timing_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Requested levels, bit 0 is input one, bit 3 input four
   input wire logic [3:0] req,
   input wire logic sel_req,
   // Levels toward the sensor
   output logic [3:0] gate,
   output logic sel
);
   // levels move at clock edges only, resets kept short
   // mode level changes between tests and twice inside the decode test
   // two-wire mode keeps input three low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gate <= 4'h0;
         sel <= 1'b1;
      end else begin
         sel <= sel_req;
         gate <= (sel_req && req[3]) ? (req & 4'hB) : req;
      end
   end
endmodule

// ==== test/current_sense_ctrl_tb.sv ====
// Self-checking bench for the reset steering and watchdog block
`timescale 1ns/1ps
module current_sense_ctrl_tb;
   import current_sense_pkg::*;
   localparam int WD = 20; // Short watchdog keeps the run brief
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   logic [3:0] req = 4'h0;
   logic sel_req = 1'b1;
   logic [3:0] gate;
   logic sel, i_rst, ln_a, ln_b, flt_n, s_rst, s_a, s_b, s_flt_n;
   out_mode_t mode, s_mode;
   logic [3:0] p;
   int err_total = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #10 ref_clk = ~ref_clk;
   gate_timing_model ctl (.clk(ref_clk), .rst_n(reset_n), .req(req), .sel_req(sel_req),
      .gate(gate), .sel(sel));
   current_sense_ctrl #(.DUAL(1'b1), .WD_CYCLES(WD)) uut (.REF_CLK(ref_clk), .RESET_N(reset_n),
      .CLK_EN(clk_en), .RESET_IN_ONE(gate[0]), .RESET_IN_TWO(gate[1]), .RESET_IN_THREE(gate[2]),
      .RESET_IN_FOUR(gate[3]), .MODE_SEL(sel), .INTEG_RESET(i_rst), .SENSE_LINE_A(ln_a),
      .SENSE_LINE_B(ln_b), .FAULT_N(flt_n), .MODE(mode));
   // Single-output variant sees the same levels
   current_sense_ctrl #(.DUAL(1'b0), .WD_CYCLES(WD)) uut_single (.REF_CLK(ref_clk),
      .RESET_N(reset_n), .CLK_EN(clk_en), .RESET_IN_ONE(gate[0]), .RESET_IN_TWO(gate[1]),
      .RESET_IN_THREE(gate[2]), .RESET_IN_FOUR(gate[3]), .MODE_SEL(sel), .INTEG_RESET(s_rst),
      .SENSE_LINE_A(s_a), .SENSE_LINE_B(s_b), .FAULT_N(s_flt_n), .MODE(s_mode));
   // Compare one value and count it
   task check(input string what, input logic [1:0] seen, input logic [1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s exp %h seen %h", what, exp, seen);
      end
   endtask
   // Drive levels, then let partner and design register them
   task apply(input logic [3:0] lv, input logic s);
      @(posedge ref_clk);
      req <= lv;
      sel_req <= s;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask
   // One reset then one measurement, lines checked
   task steer(input logic [3:0] r, input logic [3:0] m, input logic s, input logic a,
              input logic b);
      apply(r, s);
      check("reset", i_rst, 2'h1);
      apply(m, s);
      check("line_a", ln_a, a);
      check("line_b", ln_b, b);
   endtask
   // Reset function of the dual variant
   function automatic logic exp_rst(input logic s, input logic [3:0] g);
      if (!s) return (g[0] & g[1]) | (g[2] & g[3]);
      return g[3] ? ~(g[0] ^ (g[1] | g[2])) : (g[0] ^ (g[1] | g[2]));
   endfunction
   // Verdict and end of run
   task end_of_test();
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Hang guard well above the expected run length
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         end_of_test();
      end
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      #1;
      check("fault_n", flt_n, 2'h1);
      check("mode", mode, 2'h0);
      @(posedge ref_clk);
      reset_n <= 1'b1;
      // Every level combination in every mode except two-wire with input three high, both variants
      for (int i = 0; i < 32; i++) begin
         p = i[3:0];
         if (!(i[4] && p[3] && p[2])) begin
            apply(p, i[4]);
            check("reset", i_rst, exp_rst(i[4], p));
            check("mode", mode, !i[4] ? 2'h2 : (p[3] ? 2'h1 : 2'h0));
            check("single_reset", s_rst, p[0] ^ p[1]);
            check("single_mode", s_mode, 2'h0);
         end
      end
      $display("test decode done");
      steer(4'h1, 4'h0, 1'b1, 1'b1, 1'b0);
      steer(4'h1, 4'h0, 1'b1, 1'b1, 1'b0);
      check("single_line_a", s_a, 2'h1);
      check("single_line_b", s_b, 2'h0);
      $display("test single done");
      steer(4'h8, 4'h9, 1'b1, 1'b1, 1'b0);
      steer(4'h8, 4'hA, 1'b1, 1'b0, 1'b1);
      $display("test two_wire done");
      steer(4'hD, 4'h1, 1'b0, 1'b0, 1'b1);
      steer(4'h7, 4'h4, 1'b0, 1'b1, 1'b0);
      steer(4'hD, 4'h1, 1'b0, 1'b0, 1'b1);
      $display("test four_wire done");
      // No hint during the reset: lines alternate per measurement
      steer(4'hC, 4'h0, 1'b0, 1'b1, 1'b0);
      steer(4'hC, 4'h0, 1'b0, 1'b0, 1'b1);
      $display("test alternate done");
      // Measurement left running past the limit
      repeat (8) @(posedge ref_clk);
      #1;
      check("fault_n", flt_n, 2'h1);
      repeat (WD) @(posedge ref_clk);
      #1;
      check("fault_n", flt_n, 2'h0);
      check("line_b", ln_b, 2'h0);
      check("single_fault_n", s_flt_n, 2'h0);
      apply(4'hD, 1'b0);
      check("fault_n", flt_n, 2'h1);
      check("single_fault_n", s_flt_n, 2'h1);
      $display("test watchdog done");
      // Frozen clock enable holds the reset output
      @(posedge ref_clk);
      clk_en <= 1'b0;
      apply(4'h1, 1'b0);
      check("frozen_reset", i_rst, 2'h1);
      @(posedge ref_clk);
      clk_en <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      check("reset", i_rst, 2'h0);
      $display("test clock_enable done");
      end_of_test();
   end
endmodule
